//--- regmap_defines.vh
`ifndef REGMAP_DEFINES_VH
`define REGMAP_DEFINES_VH
// Register addresses on the three address lines
`define ADDR_DATA 3'h0
`define ADDR_MASK 3'h1
`define ADDR_SRC 3'h2
`define ADDR_LINE 3'h3
`define ADDR_MODEM 3'h4
`define ADDR_LSTAT 3'h5
`define ADDR_MSTAT 3'h6
`define ADDR_TOP 3'h7
// Line control value that opens the enhanced set
`define ENHANCED_KEY 8'hbf
// Field positions
`define LINE_DIV_BIT 7
`define EFN_EXT_BIT 4
`define FEAT_SWAP_BIT 6
`define FIFO_EN_BIT 0
`define FIFO_RXRST_BIT 1
`define FIFO_TXRST_BIT 2
// Extended bit masks, usable only while the enhanced-function bit is set
`define MASK_EXT 8'hf0
`define FIFO_CTL_EXT 8'h30
`define MODEM_EXT 8'he0
`define SRC_EXT 8'h30
// Reset values
`define RST_BYTE 8'h00
`define RST_LINE 8'h00
`define RST_SRC_IDLE 8'h01
`endif

//--- channel_regs.v
`include "regmap_defines.vh"
// One channel's register set and decoder
module channel_regs #(
    parameter [7:0] REV_CODE = 8'h01, // Arbitrary value
    parameter [7:0] ID_CODE = 8'h0a // Arbitrary value
) (
    input wire sys_clk,
    input wire rst_b,
    input wire sel, // Channel chosen this cycle
    input wire wr_stb, // One-cycle write strobe
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire [7:0] rx_data, // Receive holding value
    input wire [7:0] line_stat, // Line status from the datapath
    input wire [7:0] modem_stat, // Modem status from the datapath
    input wire [7:0] src_code, // Interrupt source code
    input wire [7:0] fifo_count, // Level count for readback
    output reg [7:0] rdata_next, // Combinational read data
    output reg tx_load, // Transmit holding written
    output reg [7:0] tx_data,
    output reg rx_fifo_clear,
    output reg tx_fifo_clear,
    output wire [7:0] line_q,
    output wire [7:0] modem_q,
    output wire [7:0] efn_q,
    output wire [7:0] feat_q,
    output wire [7:0] emode_q
);
    // *****************************
    // Storage
    // *****************************
    reg [7:0] dll_reg, dlh_reg, mask_reg, fctl_reg, line_reg, modem_reg, scratch_reg;
    reg [7:0] trig_reg, feat_reg, efn_reg, emode_reg;
    reg [7:0] ch_reg [0:3]; // Two resume then two pause characters
    wire enh = (line_reg == `ENHANCED_KEY);
    wire div = line_reg[`LINE_DIV_BIT] & ~enh;
    wire ext = efn_reg[`EFN_EXT_BIT];
    wire swap = feat_reg[`FEAT_SWAP_BIT];
    wire id_mode = div && (dll_reg == 8'h00) && (dlh_reg == 8'h00);
    wire we = sel & wr_stb;
    assign line_q = line_reg;
    assign modem_q = modem_reg;
    assign efn_q = efn_reg;
    assign feat_q = feat_reg;
    assign emode_q = emode_reg;

    // Keep extended bits clear unless unlocked
    function [7:0] gate;
        input [7:0] v;
        input [7:0] m;
        begin
            gate = ext ? v : (v & ~m);
        end
    endfunction
    // Source code with locked bits cleared; only the low six bits are used
    wire [7:0] src_gated = gate(src_code, `SRC_EXT);

    // *****************************
    // Read decode
    // *****************************
    always @* begin
        rdata_next = 8'h00;
        case (addr)
            `ADDR_DATA: begin
                if (enh) rdata_next = fifo_count;
                else if (id_mode) rdata_next = REV_CODE;
                else if (div) rdata_next = dll_reg;
                else rdata_next = rx_data;
            end
            `ADDR_MASK: begin
                if (enh) rdata_next = feat_reg;
                else if (id_mode) rdata_next = ID_CODE;
                else if (div) rdata_next = dlh_reg;
                else rdata_next = gate(mask_reg, `MASK_EXT);
            end
            `ADDR_SRC: begin
                if (enh) rdata_next = efn_reg;
                else rdata_next = {{2{fctl_reg[`FIFO_EN_BIT]}}, src_gated[5:0]};
            end
            `ADDR_LINE: rdata_next = line_reg;
            `ADDR_MODEM: rdata_next = enh ? ch_reg[0] : gate(modem_reg, `MODEM_EXT);
            `ADDR_LSTAT: rdata_next = enh ? ch_reg[1] : line_stat;
            `ADDR_MSTAT: rdata_next = enh ? ch_reg[2] : modem_stat;
            `ADDR_TOP: begin
                if (enh) rdata_next = ch_reg[3];
                else if (swap) rdata_next = fifo_count;
                else rdata_next = scratch_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // *****************************
    // Write decode
    // *****************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dll_reg <= `RST_BYTE;
            dlh_reg <= `RST_BYTE;
            mask_reg <= `RST_BYTE;
            fctl_reg <= `RST_BYTE;
            line_reg <= `RST_LINE;
            modem_reg <= `RST_BYTE;
            scratch_reg <= `RST_BYTE;
            trig_reg <= `RST_BYTE;
            feat_reg <= `RST_BYTE;
            efn_reg <= `RST_BYTE;
            emode_reg <= `RST_BYTE;
            ch_reg[0] <= `RST_BYTE;
            ch_reg[1] <= `RST_BYTE;
            ch_reg[2] <= `RST_BYTE;
            ch_reg[3] <= `RST_BYTE;
            tx_load <= 1'b0;
            tx_data <= `RST_BYTE;
            rx_fifo_clear <= 1'b0;
            tx_fifo_clear <= 1'b0;
        end else begin
            // Strobes last one cycle
            tx_load <= 1'b0;
            rx_fifo_clear <= 1'b0;
            tx_fifo_clear <= 1'b0;
            if (we) begin
                case (addr)
                    `ADDR_DATA: begin
                        if (enh) trig_reg <= wdata;
                        else if (div) dll_reg <= wdata;
                        else begin
                            tx_load <= 1'b1;
                            tx_data <= wdata;
                        end
                    end
                    `ADDR_MASK: begin
                        if (enh) feat_reg <= wdata;
                        else if (div) dlh_reg <= wdata;
                        else mask_reg <= ext ? wdata : ((wdata & ~`MASK_EXT) | (mask_reg & `MASK_EXT));
                    end
                    `ADDR_SRC: begin
                        if (enh) efn_reg <= wdata;
                        else begin
                            // Reset bits self-clear and are not stored
                            fctl_reg <= (ext ? wdata : ((wdata & ~`FIFO_CTL_EXT) | (fctl_reg & `FIFO_CTL_EXT)))
                                & 8'hf9;
                            rx_fifo_clear <= wdata[`FIFO_RXRST_BIT];
                            tx_fifo_clear <= wdata[`FIFO_TXRST_BIT];
                        end
                    end
                    `ADDR_LINE: line_reg <= wdata;
                    `ADDR_MODEM: begin
                        if (enh) ch_reg[0] <= wdata;
                        else modem_reg <= ext ? wdata : ((wdata & ~`MODEM_EXT) | (modem_reg & `MODEM_EXT));
                    end
                    `ADDR_LSTAT: if (enh) ch_reg[1] <= wdata;
                    `ADDR_MSTAT: if (enh) ch_reg[2] <= wdata;
                    `ADDR_TOP: begin
                        if (enh) ch_reg[3] <= wdata;
                        else if (swap) emode_reg <= wdata;
                        else scratch_reg <= wdata;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

//--- dual_uart_regs.v
`include "regmap_defines.vh"
module dual_uart_regs #(
    parameter [7:0] REV_CODE = 8'h01, // Arbitrary value
    parameter [7:0] ID_CODE = 8'h0a // Arbitrary value
) (
    input wire sys_clk,
    input wire rst_b,
    input wire channel_a_select_n, // Pin, synchronised
    input wire channel_b_select_n,
    input wire read_n, // Read strobe pin
    input wire write_n, // Write strobe pin
    input wire [2:0] addr, // Pins, synchronised
    input wire [7:0] data_in, // Data bus in
    output reg [7:0] data_out,
    output reg data_oe, // High while driving the bus
    input wire [7:0] rx_data_a,
    input wire [7:0] rx_data_b,
    input wire [7:0] line_stat_a,
    input wire [7:0] line_stat_b,
    input wire [7:0] modem_stat_a,
    input wire [7:0] modem_stat_b,
    input wire [7:0] src_code_a,
    input wire [7:0] src_code_b,
    input wire [7:0] fifo_count_a,
    input wire [7:0] fifo_count_b,
    output reg tx_load_a,
    output reg tx_load_b,
    output reg [7:0] tx_data_a,
    output reg [7:0] tx_data_b,
    output reg [7:0] line_control_a,
    output reg [7:0] line_control_b,
    output reg [7:0] modem_control_a,
    output reg [7:0] modem_control_b
);
    // *****************************
    // Pin synchronisers
    // *****************************
    reg [13:0] s1_reg, s2_reg; // First stage read only by second
    reg wr_d_reg; // Previous write strobe level
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= 14'h3fff;
            s2_reg <= 14'h3fff;
            wr_d_reg <= 1'b0;
        end else begin
            s1_reg <= {channel_a_select_n, channel_b_select_n, read_n, write_n, addr, 7'h00} | 14'h0000;
            s2_reg <= s1_reg;
            wr_d_reg <= ~s2_reg[10];
        end
    end
    reg [7:0] d1_reg, d2_reg; // Data bus synchroniser
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            d1_reg <= 8'h00;
            d2_reg <= 8'h00;
        end else begin
            d1_reg <= data_in;
            d2_reg <= d1_reg;
        end
    end
    wire sel_a = ~s2_reg[13];
    wire sel_b = ~s2_reg[12] & s2_reg[13]; // A wins if both asserted
    wire rd = ~s2_reg[11];
    wire wr_lvl = ~s2_reg[10];
    // Write takes effect at the strobe's trailing edge, data settled by then
    wire wr_stb = wr_d_reg & ~wr_lvl;
    reg sel_a_q_reg, sel_b_q_reg; // Selects held from the strobe's active phase
    reg [2:0] addr_q_reg;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_a_q_reg <= 1'b0;
            sel_b_q_reg <= 1'b0;
            addr_q_reg <= 3'h0;
        end else if (wr_lvl) begin
            sel_a_q_reg <= sel_a;
            sel_b_q_reg <= sel_b;
            addr_q_reg <= s2_reg[9:7];
        end
    end
    wire [2:0] a_use = wr_stb ? addr_q_reg : s2_reg[9:7];

    // *****************************
    // Channels
    // *****************************
    wire [7:0] rd_a, rd_b, lq_a, lq_b, mq_a, mq_b;
    wire ld_a, ld_b;
    wire [7:0] td_a, td_b;
    channel_regs #(.REV_CODE(REV_CODE), .ID_CODE(ID_CODE)) u_ch_a (
        .sys_clk(sys_clk), .rst_b(rst_b), .sel(sel_a_q_reg), .wr_stb(wr_stb), .addr(a_use),
        .wdata(d2_reg), .rx_data(rx_data_a), .line_stat(line_stat_a), .modem_stat(modem_stat_a),
        .src_code(src_code_a), .fifo_count(fifo_count_a), .rdata_next(rd_a), .tx_load(ld_a),
        .tx_data(td_a), .rx_fifo_clear(), .tx_fifo_clear(), .line_q(lq_a), .modem_q(mq_a),
        .efn_q(), .feat_q(), .emode_q()
    );
    channel_regs #(.REV_CODE(REV_CODE), .ID_CODE(ID_CODE)) u_ch_b (
        .sys_clk(sys_clk), .rst_b(rst_b), .sel(sel_b_q_reg), .wr_stb(wr_stb), .addr(a_use),
        .wdata(d2_reg), .rx_data(rx_data_b), .line_stat(line_stat_b), .modem_stat(modem_stat_b),
        .src_code(src_code_b), .fifo_count(fifo_count_b), .rdata_next(rd_b), .tx_load(ld_b),
        .tx_data(td_b), .rx_fifo_clear(), .tx_fifo_clear(), .line_q(lq_b), .modem_q(mq_b),
        .efn_q(), .feat_q(), .emode_q()
    );

    // *****************************
    // Registered outputs
    // *****************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            tx_load_a <= 1'b0;
            tx_load_b <= 1'b0;
            tx_data_a <= 8'h00;
            tx_data_b <= 8'h00;
            line_control_a <= `RST_LINE;
            line_control_b <= `RST_LINE;
            modem_control_a <= 8'h00;
            modem_control_b <= 8'h00;
        end else begin
            data_oe <= rd & (sel_a | sel_b);
            data_out <= sel_a ? rd_a : (sel_b ? rd_b : 8'h00);
            tx_load_a <= ld_a;
            tx_load_b <= ld_b;
            tx_data_a <= td_a;
            tx_data_b <= td_b;
            line_control_a <= lq_a;
            line_control_b <= lq_b;
            modem_control_a <= mq_a;
            modem_control_b <= mq_b;
        end
    end
endmodule

//--- dual_uart_regs_monitor.sv
// ****************
// Port checker
// ****************
module dual_uart_regs_monitor (
    input wire sys_clk,
    input wire rst_b,
    input wire channel_a_select_n,
    input wire channel_b_select_n,
    input wire read_n,
    input wire write_n,
    input wire [2:0] addr,
    input wire [7:0] data_out,
    input wire data_oe,
    input wire [7:0] line_stat_a,
    input wire [7:0] modem_stat_a,
    input wire tx_load_a,
    input wire tx_load_b,
    input wire [7:0] line_control_a,
    input wire [7:0] line_control_b,
    input wire [7:0] modem_control_a
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Last low cycle of a data write to A, then the strobe rises
    sequence s_wr_a0;
        (!write_n && !channel_a_select_n && addr == 3'h0 && !line_control_a[7]) ##1 write_n;
    endsequence
    // Last low cycle of a data write to B, then the strobe rises
    sequence s_wr_b0;
        (!write_n && channel_a_select_n && !channel_b_select_n && addr == 3'h0 && !line_control_b[7]) ##1 write_n;
    endsequence
    // Read strobe held on channel A long enough to be answered
    sequence s_rd_a;
        (!read_n && !channel_a_select_n) [*4];
    endsequence
    AST_TX_LOAD_A: assert property (s_wr_a0 |-> ##[1:6] tx_load_a) else $error("no load");
    AST_TX_LOAD_B: assert property (s_wr_b0 |-> ##[1:6] tx_load_b) else $error("no load b");
    AST_TX_PULSE: assert property (tx_load_a |=> !tx_load_a) else $error("long load");
    AST_TX_MODE: assert property (tx_load_a |-> !line_control_a[7]) else $error("load in div");
    AST_ONE_CH: assert property (!(tx_load_a && tx_load_b)) else $error("both loads");
    AST_OE_A: assert property (s_rd_a |-> data_oe) else $error("no drive");
    AST_LCR_ADDR: assert property (!$stable(line_control_a) |-> $past(addr, 3) == 3'h3)
        else $error("line ctl addr");
    AST_LCR_B: assert property (!$stable(line_control_b) |-> $past(channel_a_select_n, 3)
        && !$past(channel_b_select_n, 3)) else $error("b sel");
    AST_MCR_WR: assert property (!$stable(modem_control_a) |-> line_control_a != 8'hbf
        && $past(addr, 3) == 3'h4) else $error("modem wr");
    AST_LSR_RD: assert property (data_oe && addr == 3'h5 && !channel_a_select_n
        && line_control_a != 8'hbf |-> data_out == line_stat_a) else $error("lsr");
    AST_MSR_RD: assert property (data_oe && addr == 3'h6 && !channel_a_select_n
        && line_control_a != 8'hbf |-> data_out == modem_stat_a) else $error("msr");
    AST_LCR_RD: assert property (data_oe && addr == 3'h3 && !channel_a_select_n
        |-> data_out == line_control_a) else $error("lcr rd");
endmodule
bind dual_uart_regs dual_uart_regs_monitor mon_u (.sys_clk, .rst_b, .channel_a_select_n,
    .channel_b_select_n, .read_n, .write_n, .addr, .data_out, .data_oe, .line_stat_a,
    .modem_stat_a, .tx_load_a, .tx_load_b, .line_control_a, .line_control_b, .modem_control_a);

//--- dual_uart_host_model.sv
// ****************
// Host bus master
// ****************
module dual_uart_host_model (
    input wire sys_clk,
    input wire [7:0] data_out,
    input wire data_oe,
    output logic channel_a_select_n,
    output logic channel_b_select_n,
    output logic read_n,
    output logic write_n,
    output logic [2:0] addr,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus, nothing selected
    initial begin
        {channel_a_select_n, channel_b_select_n, read_n, write_n} = 4'hf;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // Select one channel only; released after each access
    task automatic sel(input bit ch, input logic [2:0] a);
        channel_a_select_n <= ch;
        channel_b_select_n <= !ch;
        addr <= a;
    endtask
    task automatic idle();
        repeat (3) @(posedge sys_clk);
        channel_a_select_n <= 1'b1;
        channel_b_select_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    // Write: strobe low 3 cycles, data held, then bus inverted
    task automatic wr(input bit ch, input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sel(ch, a);
        data_in <= d;
        write_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        write_n <= 1'b1;
        idle();
        data_in <= ~d;
    endtask
    // Read: unknown if the device is not driving
    task automatic rd(input bit ch, input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        sel(ch, a);
        read_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        d = data_oe ? data_out : 8'hxx;
        read_n <= 1'b1;
        idle();
    endtask
endmodule

//--- dual_uart_regs_tb_top.sv
// ****************
// Testbench
// ****************
module dual_uart_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b;
    logic [7:0] rx_data_a, rx_data_b, line_stat_a, line_stat_b, modem_stat_a, modem_stat_b;
    logic [7:0] src_code_a, src_code_b, fifo_count_a, fifo_count_b;
    wire channel_a_select_n, channel_b_select_n, read_n, write_n, data_oe;
    wire [2:0] addr;
    wire [7:0] data_in, data_out, tx_data_a, tx_data_b;
    wire tx_load_a, tx_load_b;
    wire [7:0] line_control_a, line_control_b, modem_control_a, modem_control_b;
    int n_mismatch = 0;
    int check_count = 0;
    dual_uart_regs dut_u (.sys_clk, .rst_b, .channel_a_select_n, .channel_b_select_n, .read_n,
        .write_n, .addr, .data_in, .data_out, .data_oe, .rx_data_a, .rx_data_b, .line_stat_a,
        .line_stat_b, .modem_stat_a, .modem_stat_b, .src_code_a, .src_code_b, .fifo_count_a,
        .fifo_count_b, .tx_load_a, .tx_load_b, .tx_data_a, .tx_data_b, .line_control_a,
        .line_control_b, .modem_control_a, .modem_control_b);
    dual_uart_host_model host_u (.sys_clk, .data_out, .data_oe, .channel_a_select_n,
        .channel_b_select_n, .read_n, .write_n, .addr, .data_in);
    // 50 MHz clock
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // Byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read one register and compare
    task automatic rc(input bit ch, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd(ch, a, v);
        chk(v, e);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic final_report();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog, far beyond the roughly 500 cycles needed
    initial begin
        #200us;
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial begin
        rst_b = 1'b0;
        {rx_data_a, rx_data_b, line_stat_a, line_stat_b} = 32'h3cc36061;
        {modem_stat_a, modem_stat_b, src_code_a, src_code_b} = 32'hb00b0c01;
        {fifo_count_a, fifo_count_b} = 16'h2772;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        host_u.wr(0, 3'h3, 8'h1b);
        rc(0, 3'h3, 8'h1b);
        rc(1, 3'h3, 8'h00);
        host_u.wr(0, 3'h0, 8'h5a);
        chk(tx_data_a, 8'h5a);
        rc(0, 3'h0, 8'h3c);
        rc(1, 3'h0, 8'hc3);
        host_u.wr(1, 3'h3, 8'h07);
        chk(line_control_b, 8'h07);
        chk(line_control_a, 8'h1b);
        host_u.wr(1, 3'h0, 8'h66);
        chk(tx_data_b, 8'h66);
        chk(tx_data_a, 8'h5a);
        host_u.wr(1, 3'h4, 8'h03);
        chk(modem_control_b, 8'h03);
        chk(modem_control_a, 8'h00);
        done("data and select");
        host_u.wr(0, 3'h1, 8'hff);
        rc(0, 3'h1, 8'h0f);
        host_u.wr(0, 3'h4, 8'he3);
        chk(modem_control_a, 8'h03);
        rc(0, 3'h2, 8'h0c);
        host_u.wr(0, 3'h2, 8'h01);
        rc(0, 3'h2, 8'hcc);
        host_u.wr(0, 3'h7, 8'ha5);
        rc(0, 3'h7, 8'ha5);
        done("standard set");
        host_u.wr(0, 3'h5, 8'hff);
        host_u.wr(0, 3'h6, 8'hff);
        rc(0, 3'h5, 8'h60);
        rc(0, 3'h6, 8'hb0);
        rc(1, 3'h5, 8'h61);
        rc(0, 3'h3, 8'h1b);
        done("status");
        host_u.wr(0, 3'h3, 8'h80);
        rc(0, 3'h0, 8'h01);
        rc(0, 3'h1, 8'h0a);
        host_u.wr(0, 3'h0, 8'h12);
        host_u.wr(0, 3'h1, 8'h34);
        rc(0, 3'h0, 8'h12);
        rc(0, 3'h1, 8'h34);
        done("divisor");
        host_u.wr(0, 3'h3, 8'hbf);
        rc(0, 3'h0, 8'h27);
        host_u.wr(0, 3'h2, 8'h10);
        rc(0, 3'h2, 8'h10);
        host_u.wr(0, 3'h1, 8'h40);
        rc(0, 3'h1, 8'h40);
        for (int i = 4; i < 8; i++) begin
            host_u.wr(0, i[2:0], 8'h90 + i[7:0]);
        end
        for (int i = 4; i < 8; i++) begin
            rc(0, i[2:0], 8'h90 + i[7:0]);
        end
        done("enhanced");
        host_u.wr(0, 3'h3, 8'h03);
        rc(0, 3'h7, 8'h27);
        host_u.wr(0, 3'h1, 8'hf3);
        rc(0, 3'h1, 8'hf3);
        host_u.wr(0, 3'h4, 8'he3);
        chk(modem_control_a, 8'he3);
        done("unlocked");
        final_report();
    end
endmodule
